// ===== src/ssc_top.sv
// Serial switch control: 2-wire receive-only slave and 3-wire shift port
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Bit 2 drives SPST, bit 1 throw B, bit 0 throw A; bits 7..3 ignored.
// - Applied command bit 1 closes its switch, bit 0 opens it.
// - Power-up preset: SPST open, throw B closed, throw A open.
// - Both transports deliver the same command byte format.
// - Slave answers only address 01101A10, A taken from the select pin.
// - Matching address is acknowledged by pulling data low one clock period.
// - Command byte is acknowledged by pulling data low one clock period.
// - Slave only receives and acknowledges; master drives all transactions.
// - Data falling while clock high is a start condition.
// - Data rising while clock high is a stop; bus then free.
// - Slave always watches for start plus address regardless of history.
// - Shift register takes bits only while chip select is low.
// - Shift register samples data on each serial clock rising edge.
// - Each 3-wire write is eight bits, most significant first.
// - Switch states stay unchanged while bits are shifting.
// - Chip select rising after eight bits loads the command into switches.
// - 2-wire update happens at the falling edge before the command acknowledge.
// - 3-wire update happens at the chip select rising edge.
module ssc_top
(
    input  wire logic           clk,
    input  wire logic           nrst,
    input  wire logic           tw_scl,
    input  wire logic           tw_sda_i,
    output logic                tw_sda_o,
    output logic                tw_sda_oe,
    input  wire logic           addr_sel,
    input  wire logic           sw_sclk,
    input  wire logic           sw_din,
    input  wire logic           sw_cs_n,
    output ssc_pkg::ssc_sw_t    sw_state
);
    import ssc_pkg::*;

    // Two-flop synchronisers for every pin; stage one is read only by stage two
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] prev;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1 <= 5'h1f;
            sync2 <= 5'h1f;
            prev  <= 5'h1f;
        end
        else
        begin
            sync1 <= {tw_scl, tw_sda_i, sw_sclk, sw_din, sw_cs_n};
            sync2 <= sync1;
            prev  <= sync2;
        end
    end

    // Clean pin levels and edge detects
    wire scl_s      = sync2[4];
    wire sda_s      = sync2[3];
    wire sclk_s     = sync2[2];
    wire din_s      = sync2[1];
    wire cs_n_s     = sync2[0];
    wire scl_rise   = scl_s & ~prev[4];
    wire scl_fall   = ~scl_s & prev[4];
    wire sclk_rise  = sclk_s & ~prev[2];
    wire cs_rise    = cs_n_s & ~prev[0];
    wire start_cond = scl_s & prev[4] & ~sda_s & prev[3];
    wire stop_cond  = scl_s & prev[4] & sda_s & ~prev[3];

    // Address select pin is static but still passes two flops like any other pin
    logic addr_pin_s1;
    logic addr_pin_s2;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            addr_pin_s1 <= 1'b0;
            addr_pin_s2 <= 1'b0;
        end
        else
        begin
            addr_pin_s1 <= addr_sel;
            addr_pin_s2 <= addr_pin_s1;
        end
    end
    wire [7:0] own_addr = {ADDR_HI, addr_pin_s2, ADDR_LO};

    // 2-wire receiver state
    ssc_state_t      state;
    ssc_state_t      next_state;
    logic [7:0]      tw_shift;
    logic [3:0]      tw_cnt;
    logic            ack_drive;

    wire [7:0] tw_byte   = {tw_shift[6:0], sda_s};
    wire       last_bit  = scl_rise & (tw_cnt == BIT_CNT_FULL - 4'h1);
    wire       addr_hit  = tw_byte == own_addr;
    wire       eighth_fall = scl_fall & (tw_cnt == BIT_CNT_ACK);
    wire       tw_apply  = (state == ST_CMD) & eighth_fall;

    // Next state; start and stop override everything
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:     next_state = ST_IDLE;
            ST_ADDR:     if (last_bit) next_state = addr_hit ? ST_ACK_ADDR : ST_IGNORE;
            ST_ACK_ADDR: if (scl_fall & ack_drive) next_state = ST_CMD;
            ST_CMD:      if (eighth_fall) next_state = ST_ACK_CMD;
            ST_ACK_CMD:  if (scl_fall & ack_drive) next_state = ST_IGNORE;
            ST_IGNORE:   next_state = ST_IGNORE;
            default:     next_state = ST_IDLE;
        endcase
        if (start_cond)
            next_state = ST_ADDR;
        else if (stop_cond)
            next_state = ST_IDLE;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // Bit counter and shifter; counter reaches 8 after the eighth rising edge of the command byte, but holds at 7 on the address byte
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tw_cnt   <= 4'h0;
            tw_shift <= 8'h00;
        end
        else if (start_cond || (next_state != state))
        begin
            tw_cnt   <= (next_state == ST_CMD && state != ST_ADDR) ? 4'h0 : tw_cnt;
            tw_shift <= tw_shift;
            if (start_cond)
                tw_cnt <= 4'h0;
        end
        else if (scl_rise && (state == ST_ADDR || state == ST_CMD) && tw_cnt != BIT_CNT_FULL)
        begin
            tw_shift <= tw_byte;   // MSB first
            tw_cnt   <= tw_cnt + 4'h1;
        end
    end

    // Acknowledge: drive low from the falling edge after bit 8 to the next falling edge
    // The command acknowledge starts on the same fall that applies the command, else it comes a clock late
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            ack_drive <= 1'b0;
        else if (start_cond || stop_cond)
            ack_drive <= 1'b0;
        else if ((scl_fall && state == ST_ACK_ADDR && !ack_drive) || tw_apply)
            ack_drive <= 1'b1;
        else if (scl_fall)
            ack_drive <= 1'b0;
    end

    // Open-drain data pin: only ever pulled low, never returns data
    assign tw_sda_o  = 1'b0;
    assign tw_sda_oe = ack_drive;

    // 3-wire shift register and frame bit count
    logic [7:0] sp_shift;
    logic [3:0] sp_cnt;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sp_shift <= 8'h00;
            sp_cnt   <= 4'h0;
        end
        else if (cs_n_s)
            sp_cnt   <= 4'h0;
        else if (sclk_rise)
        begin
            sp_shift <= {sp_shift[6:0], din_s};
            sp_cnt   <= (sp_cnt == BIT_CNT_FULL) ? sp_cnt : sp_cnt + 4'h1;
        end
    end
    // Short frames are dropped; longer keep the last eight bits
    wire sp_apply = cs_rise & (prev[0] == 1'b0) & (sp_cnt == BIT_CNT_FULL);

    // Command decode shared by both transports
    function automatic ssc_sw_t decode_cmd(input logic [CMD_W-1:0] cmd);
        ssc_sw_t s;
        s.spst_throw   = cmd[SPST_BIT];
        s.spdt_throw_b = cmd[THROW_B_BIT];
        s.spdt_throw_a = cmd[THROW_A_BIT];
        return s;
    endfunction : decode_cmd

    // Switch register; holds during shifting, updates only on apply
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            sw_state <= SW_PRESET;
        else if (sp_apply)
            sw_state <= decode_cmd(sp_shift);
        else if (tw_apply)
            sw_state <= decode_cmd(tw_shift);
    end

    // Assertions
    logic past_valid;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            past_valid <= 1'b0;
        else
            past_valid <= 1'b1;
    end

    property p_preset;
        @(posedge clk) $rose(nrst) |-> sw_state == SW_PRESET;
    endproperty
    a_preset: assert property (p_preset) else $error("preset wrong");

    property p_sp_load;
        @(posedge clk) disable iff (!nrst) sp_apply |=> sw_state == $past(sp_shift[2:0]);
    endproperty
    a_sp_load: assert property (p_sp_load) else $error("3-wire load wrong");

    property p_hold;
        @(posedge clk) disable iff (!nrst) past_valid && !sp_apply && !tw_apply |=> $stable(sw_state);
    endproperty
    a_hold: assert property (p_hold) else $error("switches moved without apply");

    property p_tw_load;
        @(posedge clk) disable iff (!nrst) tw_apply && !sp_apply |=> sw_state == $past(tw_shift[2:0]);
    endproperty
    a_tw_load: assert property (p_tw_load) else $error("2-wire load wrong");

    property p_nack;
        @(posedge clk) disable iff (!nrst) state == ST_IGNORE |-> !tw_sda_oe;
    endproperty
    a_nack: assert property (p_nack) else $error("drove data while ignoring");

    property p_start;
        @(posedge clk) disable iff (!nrst) start_cond |=> state == ST_ADDR && tw_cnt == 4'h0;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");

    property p_stop;
        @(posedge clk) disable iff (!nrst) stop_cond && !start_cond |=> state == ST_IDLE && !tw_sda_oe;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not taken");

    property p_ack_addr;
        @(posedge clk) disable iff (!nrst) state == ST_ACK_ADDR && scl_fall && !ack_drive && !start_cond
            && !stop_cond |=> tw_sda_oe;
    endproperty
    a_ack_addr: assert property (p_ack_addr) else $error("no address acknowledge");

    property p_cs_only;
        @(posedge clk) disable iff (!nrst) cs_n_s |=> sp_cnt == 4'h0;
    endproperty
    a_cs_only: assert property (p_cs_only) else $error("counted while deselected");

    property p_short;
        @(posedge clk) disable iff (!nrst) cs_rise && sp_cnt != BIT_CNT_FULL && !tw_apply |=> $stable(sw_state);
    endproperty
    a_short: assert property (p_short) else $error("short frame applied");

    // 2-wire acknowledge and framing checks
    property p_cmd_ack;
        @(posedge clk) disable iff (!nrst) tw_apply |=> tw_sda_oe;
    endproperty
    a_cmd_ack: assert property (p_cmd_ack) else $error("no command acknowledge");

    property p_ack_len;
        @(posedge clk) disable iff (!nrst) tw_sda_oe && scl_fall |=> !tw_sda_oe;
    endproperty
    a_ack_len: assert property (p_ack_len) else $error("acknowledge longer than one clock");

    property p_ack_addr_end;
        @(posedge clk) disable iff (!nrst) state == ST_ACK_ADDR && scl_fall && ack_drive
            |=> state == ST_CMD && tw_cnt == 4'h0 && !tw_sda_oe;
    endproperty
    a_ack_addr_end: assert property (p_ack_addr_end) else $error("address acknowledge did not end");

    property p_cmd_done;
        @(posedge clk) disable iff (!nrst) state == ST_ACK_CMD && scl_fall && ack_drive
            |=> state == ST_IGNORE && !tw_sda_oe;
    endproperty
    a_cmd_done: assert property (p_cmd_done) else $error("extra byte not ignored");

    property p_addr_miss;
        @(posedge clk) disable iff (!nrst) state == ST_ADDR && last_bit && !addr_hit |=> state == ST_IGNORE;
    endproperty
    a_addr_miss: assert property (p_addr_miss) else $error("foreign address not ignored");

    property p_ign_hold;
        @(posedge clk) disable iff (!nrst) state == ST_IGNORE && !start_cond && !stop_cond |=> state == ST_IGNORE;
    endproperty
    a_ign_hold: assert property (p_ign_hold) else $error("left ignore without start or stop");

    property p_ack_only;
        @(posedge clk) disable iff (!nrst) tw_sda_oe |-> state == ST_ACK_ADDR || state == ST_ACK_CMD;
    endproperty
    a_ack_only: assert property (p_ack_only) else $error("data driven outside an acknowledge");

    // 3-wire port checks
    property p_shift_in;
        @(posedge clk) disable iff (!nrst) sclk_rise && !cs_n_s
            |=> sp_shift == {$past(sp_shift[6:0]), $past(din_s)};
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("shift register missed a bit");

    property p_cs_freeze;
        @(posedge clk) disable iff (!nrst) cs_n_s |=> $stable(sp_shift);
    endproperty
    a_cs_freeze: assert property (p_cs_freeze) else $error("shifted while deselected");

    property p_sp_keep;
        @(posedge clk) disable iff (!nrst) !cs_n_s && !tw_apply |=> $stable(sw_state);
    endproperty
    a_sp_keep: assert property (p_sp_keep) else $error("switches moved while shifting");

    property p_cnt_max;
        @(posedge clk) disable iff (!nrst) sp_cnt <= BIT_CNT_FULL;
    endproperty
    a_cnt_max: assert property (p_cnt_max) else $error("frame count overran");

    // Cover points for the main scenarios
    c_short: cover property (@(posedge clk) disable iff (!nrst) cs_rise && sp_cnt != BIT_CNT_FULL);
    c_sp: cover property (@(posedge clk) disable iff (!nrst) sp_apply);
    c_tw: cover property (@(posedge clk) disable iff (!nrst) tw_apply);
    c_ign: cover property (@(posedge clk) disable iff (!nrst) state == ST_IGNORE);
    c_ack: cover property (@(posedge clk) disable iff (!nrst) state == ST_ACK_CMD && tw_sda_oe);
endmodule : ssc_top

`default_nettype wire

// ===== src/ssc_pkg.sv
// Package for the serial switch control block: command layout, addresses, presets
package ssc_pkg;
    localparam int          CMD_W           = 8;
    localparam int          SPST_BIT        = 2;
    localparam int          THROW_B_BIT     = 1;
    localparam int          THROW_A_BIT     = 0;
    localparam logic [2:0]  SW_PRESET       = 3'h2;    // Throw B closed, others open
    localparam logic [4:0]  ADDR_HI         = 5'h0d;   // 01101 above the select bit
    localparam logic [1:0]  ADDR_LO         = 2'h2;    // 10 below the select bit
    localparam logic [3:0]  BIT_CNT_FULL    = 4'h8;
    localparam logic [3:0]  BIT_CNT_ACK     = 4'h8;

    // Switch state carried as one struct
    typedef struct packed {
        logic spst_throw;
        logic spdt_throw_b;
        logic spdt_throw_a;
    } ssc_sw_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK_ADDR,
        ST_CMD,
        ST_ACK_CMD,
        ST_IGNORE
    } ssc_state_t;
endpackage : ssc_pkg

// ===== bench/ssc_master.sv
// Bus master model driving the 2-wire and 3-wire serial lines
`timescale 1ns/1ns
`default_nettype none
module ssc_master
(
    input  wire logic sda,
    output var logic  scl,
    output var logic  sda_low,
    output var logic  sclk,
    output var logic  din,
    output var logic  cs_n
);
    // Lines idle high, shift data and shift clock start low
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
        sclk = 1'b0;
        din = 1'b0;
        cs_n = 1'b1;
    end

    // Data falls while the clock is high; also serves as a repeated start
    task automatic tw_start;
        #16 sda_low = 1'b0;
        #24 scl = 1'b1;
        #40 sda_low = 1'b1;
        #40 scl = 1'b0;
    endtask : tw_start

    // Eight bits MSB first, data moves only while the clock is low, then the ack slot
    task automatic tw_byte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            #16 sda_low = !d[i];
            #24 scl = 1'b1;
            #40 scl = 1'b0;
        end
        #16 sda_low = 1'b0;
        #24 scl = 1'b1;
        #24 ack = !sda;
        #16 scl = 1'b0;
    endtask : tw_byte

    // Data rises while the clock is high, leaving the bus free
    task automatic tw_stop;
        #16 sda_low = 1'b1;
        #24 scl = 1'b1;
        #40 sda_low = 1'b0;
        #40;
    endtask : tw_stop

    // Only this device's select goes low for the frame
    task automatic spi_select;
        cs_n = 1'b0;
        #40;
    endtask : spi_select

    // Bits MSB first on clock rises; data shows the inverse afterwards as its hold is over
    task automatic spi_bits(input logic [15:0] d, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            din = d[i];
            #40 sclk = 1'b1;
            #40 sclk = 1'b0;
        end
        din = ~din;
    endtask : spi_bits

    // Select rises to execute the frame
    task automatic spi_release;
        #40 cs_n = 1'b1;
        #40;
    endtask : spi_release
endmodule : ssc_master
`default_nettype wire

// ===== bench/ssc_top_tb.sv
// Self-checking testbench for the serial switch control block
`timescale 1ns/1ns
`default_nettype none
module ssc_top_tb;
    import ssc_pkg::*;
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic       addr_sel = 1'b0;
    wire logic  scl, sda_low, sclk, din, cs_n, sda, tw_sda_o, tw_sda_oe;
    ssc_sw_t    sw_state;
    logic       ka, kc, k3;
    int         n_mismatch = 0;
    int         n_checks = 0;
    // Address table: select pin, address, command, expected ack, expected switches
    logic [7:0] t_sel [4] = '{8'h0, 8'h0, 8'h1, 8'h1};
    logic [7:0] t_adr [4] = '{8'h6a, 8'h6e, 8'h6e, 8'h6a};
    logic [7:0] t_cmd [4] = '{8'hf9, 8'h07, 8'h04, 8'h03};
    logic [7:0] t_ack [4] = '{8'h1, 8'h0, 8'h1, 8'h0};
    logic [7:0] t_sw  [4] = '{8'h01, 8'h01, 8'h04, 8'h04};

    // Open-drain wire with pull-up: low if either party pulls
    assign sda = !(sda_low || (tw_sda_oe && !tw_sda_o));

    // 125 MHz clock
    always #4 clk = ~clk;

    ssc_top ssc_top_inst (.clk(clk), .nrst(nrst), .tw_scl(scl), .tw_sda_i(sda), .tw_sda_o(tw_sda_o),
        .tw_sda_oe(tw_sda_oe), .addr_sel(addr_sel), .sw_sclk(sclk), .sw_din(din), .sw_cs_n(cs_n),
        .sw_state(sw_state));
    ssc_master ssc_master_inst (.sda(sda), .scl(scl), .sda_low(sda_low), .sclk(sclk), .din(din),
        .cs_n(cs_n));

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    // Watchdog sized well past the whole sequence
    initial
    begin
        #100000;
        n_mismatch++;
        stop_test();
    end

    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        #1 nrst = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        check("sw_state", {5'h0, sw_state}, 8'h02);
        check("tw_sda_oe", {7'h0, tw_sda_oe}, 8'h00);
        // Address matches only with the select bit, command bits 7..3 ignored
        for (int i = 0; i < 4; i++)
        begin
            addr_sel = t_sel[i][0];
            ssc_master_inst.tw_start();
            ssc_master_inst.tw_byte(t_adr[i], ka);
            ssc_master_inst.tw_byte(t_cmd[i], kc);
            check("sw_state", {5'h0, sw_state}, t_sw[i]);
            ssc_master_inst.tw_stop();
            check("addr_ack", {7'h0, ka}, t_ack[i]);
            check("cmd_ack", {7'h0, kc}, t_ack[i]);
        end
        // Rejected address, then a repeated start without stop is still seen
        ssc_master_inst.tw_start();
        ssc_master_inst.tw_byte(8'h6a, ka);
        ssc_master_inst.tw_start();
        ssc_master_inst.tw_byte(8'h6e, ka);
        ssc_master_inst.tw_byte(8'h05, kc);
        ssc_master_inst.tw_byte(8'h02, k3);
        ssc_master_inst.tw_stop();
        check("addr_ack", {7'h0, ka}, 8'h01);
        check("sw_state", {5'h0, sw_state}, 8'h05);
        check("cmd_ack", {7'h0, kc}, 8'h01);
        check("extra_ack", {7'h0, k3}, 8'h00);
        // Shift port: unchanged while shifting, applied on select rise
        ssc_master_inst.spi_select();
        ssc_master_inst.spi_bits(16'h00fb, 8);
        check("sw_state", {5'h0, sw_state}, 8'h05);
        ssc_master_inst.spi_release();
        #80;
        check("sw_state", {5'h0, sw_state}, 8'h03);
        // Short frame is dropped
        ssc_master_inst.spi_select();
        ssc_master_inst.spi_bits(16'h0004, 5);
        ssc_master_inst.spi_release();
        #80;
        check("sw_state", {5'h0, sw_state}, 8'h03);
        // Long frame keeps the last eight bits
        ssc_master_inst.spi_select();
        ssc_master_inst.spi_bits(16'h05fe, 12);
        ssc_master_inst.spi_release();
        #80;
        check("sw_state", {5'h0, sw_state}, 8'h06);
        // Clocking with select high, then an empty frame, changes nothing
        ssc_master_inst.spi_bits(16'h0001, 8);
        ssc_master_inst.spi_select();
        ssc_master_inst.spi_release();
        #80;
        check("sw_state", {5'h0, sw_state}, 8'h06);
        stop_test();
    end
endmodule : ssc_top_tb
`default_nettype wire
